/* verilog/urp_defines.vh */
// constants for the ulpi register access protocol block
`ifndef URP_DEFINES_VH
`define URP_DEFINES_VH

`define URP_CMD_IDLE      2'b00
`define URP_CMD_TX        2'b01
`define URP_CMD_WR        2'b10
`define URP_CMD_RD        2'b11
`define URP_ADDR_EXT      6'b101111
`define URP_IDLE_BYTE     8'h00
`define URP_NOPID         6'b000000
`define URP_RXC_LS_LSB    0
`define URP_RXC_VB_LSB    2
`define URP_RXC_EV_LSB    4
`define URP_NXT_DELAY     2
`define URP_REG_DEPTH     256
`define URP_REG_RESET     8'h00

`endif

/* verilog/urp_reg_array.v */
// register array with one write port and one read port
`timescale 1ns/10ps
`default_nettype none
module urp_reg_array (
	input  wire       clk_sys,
	input  wire       rst_n,
	input  wire       wr_en,
	input  wire [7:0] wr_addr,
	input  wire [7:0] wr_data,
	input  wire [7:0] rd_addr,
	output wire [7:0] rd_data
);
`include "urp_defines.vh"

	reg [7:0] mem_ff [0:`URP_REG_DEPTH-1];

	genvar gi;
	generate
		for (gi = 0; gi < `URP_REG_DEPTH; gi = gi + 1) begin : g_reg
			// contents depend on reset and writes only, never on power mode
			always @(posedge clk_sys or negedge rst_n) begin
				if (!rst_n) begin
					mem_ff[gi] <= `URP_REG_RESET;
				end else if (wr_en && (wr_addr == gi)) begin
					mem_ff[gi] <= wr_data;
				end
			end
		end
	endgenerate

	assign rd_data = mem_ff[rd_addr];
endmodule // urp_reg_array
`default_nettype wire

/* verilog/urp_protocol.v */
// ulpi phy-side protocol block: command decode, register access, rx status bytes
// What this block does
// - command 00/000000 is idle; 01/000000 is transmit without pid
// - transmit command 01/00xxxx carries the pid in bits 3:0
// - upper bits 10 mean immediate write, low six bits are the address
// - write with address 101111 is extended; full address follows in the cycle after the first nxt cycle
// - upper bits 11 mean immediate read, low six bits are the address
// - extended read uses address 2fh; address byte follows after nxt
// - register contents survive low power, serial and carkit modes
// - on write nxt rises two cycles after command, falls on data accept
// - the written value is committed only once stp deasserts
// - extended write sends address then data after nxt; device lowers nxt
// - on read nxt accepts the command; then dir rises as nxt falls
// - after turnaround drive register value one cycle, then drop dir
// - extended read captures address byte, then dir up and nxt down together
// - status bytes report line state, rx events, vbus and id state
// - status bytes only in synchronous mode while dir is high
// - one turnaround cycle on each dir change, bus ignored then
// - status raised during transmit waits until stp ends the transmit, sends current status
// - status byte bits 1:0 line state, 3:2 vbus, 5:4 rx event
`timescale 1ns/10ps
`default_nettype none
module urp_protocol (
	input  wire       clk_sys,
	input  wire       rst_n,
	input  wire [7:0] data_in,
	output reg  [7:0] data_out,
	output wire       data_oe,
	output wire       dir,
	output wire       nxt,
	input  wire       stp,
	input  wire       sync_mode,
	input  wire [1:0] line_state,
	input  wire [1:0] vbus_state,
	input  wire [1:0] rx_event,
	input  wire       id_state,
	input  wire       status_req,
	output reg        tx_start,
	output reg  [3:0] tx_pid
);
`include "urp_defines.vh"

	localparam ST_IDLE   = 4'd0;
	localparam ST_WAIT   = 4'd1;
	localparam ST_WNXT   = 4'd2;
	localparam ST_WEXT   = 4'd3;
	localparam ST_WDATA  = 4'd4;
	localparam ST_WSTP   = 4'd5;
	localparam ST_RNXT   = 4'd6;
	localparam ST_REXT   = 4'd7;
	localparam ST_RTA    = 4'd8;
	localparam ST_RDRV   = 4'd9;
	localparam ST_TX     = 4'd10;
	localparam ST_STA    = 4'd11;
	localparam ST_SDRV   = 4'd12;
	localparam ST_BACK   = 4'd13;

	reg [3:0] state_ff;
	reg [3:0] nxt_state;
	reg [7:0] cmd_ff;
	reg [7:0] nxt_cmd;
	reg [7:0] addr_ff;
	reg [7:0] nxt_addr;
	reg [7:0] wdata_ff;
	reg [7:0] nxt_wdata;
	reg       pend_ff;
	reg       nxt_pend;
	reg       wr_en;
	reg       dir_ff;
	reg       nxt_dir;
	reg       nxt_nxt;
	reg       nxt_ff;
	reg [7:0] nxt_data_out;
	reg       nxt_tx_start;
	reg [3:0] nxt_tx_pid;
	wire [7:0] rd_data;
	wire [7:0] status_byte;

	// id state has no slot in bits 5:0, carried in bit 6
	assign status_byte = {1'b0, id_state, rx_event, vbus_state, line_state};
	assign dir         = dir_ff;
	assign nxt         = nxt_ff;
	// drive only while owning the bus and past the turnaround
	assign data_oe     = dir_ff && (state_ff == ST_RDRV || state_ff == ST_SDRV);

	urp_reg_array u_regs (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.wr_en   (wr_en),
		.wr_addr (addr_ff),
		.wr_data (wdata_ff),
		.rd_addr (addr_ff),
		.rd_data (rd_data)
	);

	always @* begin
		nxt_state    = state_ff;
		nxt_cmd      = cmd_ff;
		nxt_addr     = addr_ff;
		nxt_wdata    = wdata_ff;
		nxt_pend     = pend_ff | status_req;
		nxt_dir      = dir_ff;
		nxt_nxt      = 1'b0;
		nxt_data_out = `URP_IDLE_BYTE;
		nxt_tx_start = 1'b0;
		nxt_tx_pid   = tx_pid;
		wr_en        = 1'b0;
		case (state_ff)
			ST_IDLE: begin
				if (data_in != `URP_IDLE_BYTE) begin
					// command seen at t0; nxt rises two edges later
					nxt_cmd   = data_in;
					nxt_state = ST_WAIT;
				end else if (pend_ff && sync_mode) begin
					nxt_dir   = 1'b1;
					nxt_state = ST_STA;
				end
			end
			ST_WAIT: begin
				nxt_addr = {2'b00, cmd_ff[5:0]};
				case (cmd_ff[7:6])
					`URP_CMD_WR: begin
						nxt_nxt   = 1'b1;
						nxt_state = ST_WNXT;
					end
					`URP_CMD_RD: begin
						nxt_nxt   = 1'b1;
						nxt_state = ST_RNXT;
					end
					`URP_CMD_TX: begin
						nxt_nxt      = 1'b1;
						nxt_tx_start = 1'b1;
						nxt_tx_pid   = (cmd_ff[5:0] == `URP_NOPID) ? 4'h0 : cmd_ff[3:0];
						nxt_state    = ST_TX;
					end
					default: begin
						nxt_state = ST_IDLE;
					end
				endcase
			end
			ST_WNXT: begin
				// first nxt cycle: the link only answers in the cycle after it
				nxt_nxt   = 1'b1;
				nxt_state = (cmd_ff[5:0] == `URP_ADDR_EXT) ? ST_WEXT : ST_WDATA;
			end
			ST_WEXT: begin
				nxt_nxt   = 1'b1;
				nxt_addr  = data_in;
				nxt_state = ST_WDATA;
			end
			ST_WDATA: begin
				// data accepted at this edge, nxt drops in the next cycle
				nxt_wdata = data_in;
				nxt_state = ST_WSTP;
			end
			ST_WSTP: begin
				// data accepted, nxt low; commit after stp falls
				if (!stp) begin
					wr_en     = 1'b1;
					nxt_state = ST_IDLE;
				end
			end
			ST_RNXT: begin
				if (cmd_ff[5:0] == `URP_ADDR_EXT) begin
					// keep nxt up for the cycle that carries the address byte
					nxt_nxt   = 1'b1;
					nxt_state = ST_REXT;
				end else begin
					nxt_dir   = 1'b1;
					nxt_state = ST_RTA;
				end
			end
			ST_REXT: begin
				nxt_addr  = data_in;
				nxt_dir   = 1'b1;
				nxt_state = ST_RTA;
			end
			ST_RTA: begin
				nxt_data_out = rd_data;
				nxt_state    = ST_RDRV;
			end
			ST_RDRV: begin
				nxt_dir   = 1'b0;
				nxt_state = ST_BACK;
			end
			ST_TX: begin
				nxt_nxt = 1'b1;
				if (stp) begin
					nxt_nxt   = 1'b0;
					nxt_state = ST_BACK;
				end
			end
			ST_STA: begin
				// status sampled at send time
				nxt_data_out = status_byte;
				nxt_pend     = status_req;
				nxt_state    = ST_SDRV;
			end
			ST_SDRV: begin
				nxt_dir   = 1'b0;
				nxt_state = ST_BACK;
			end
			ST_BACK: begin
				// turnaround after dir falls, bus ignored
				nxt_state = ST_IDLE;
			end
			default: begin
				nxt_state = ST_IDLE;
				nxt_dir   = 1'b0;
			end
		endcase
		if (!sync_mode) begin
			nxt_pend = 1'b0;
		end
	end

	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state_ff <= ST_IDLE;
			cmd_ff   <= `URP_IDLE_BYTE;
			addr_ff  <= 8'h00;
			wdata_ff <= 8'h00;
			pend_ff  <= 1'b0;
			dir_ff   <= 1'b0;
			nxt_ff   <= 1'b0;
			data_out <= `URP_IDLE_BYTE;
			tx_start <= 1'b0;
			tx_pid   <= 4'h0;
		end else begin
			state_ff <= nxt_state;
			cmd_ff   <= nxt_cmd;
			addr_ff  <= nxt_addr;
			wdata_ff <= nxt_wdata;
			pend_ff  <= nxt_pend;
			dir_ff   <= nxt_dir;
			nxt_ff   <= nxt_nxt;
			data_out <= nxt_data_out;
			tx_start <= nxt_tx_start;
			tx_pid   <= nxt_tx_pid;
		end
	end
endmodule // urp_protocol
`default_nettype wire

/* dv/urp_props.sv */
// assertions on the ulpi protocol block ports
`timescale 1ns/10ps
`default_nettype none
module urp_props (
	input wire logic       clk_sys,
	input wire logic       rst_n,
	input wire logic [7:0] data_in,
	input wire logic       data_oe,
	input wire logic       dir,
	input wire logic       nxt,
	input wire logic       sync_mode
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	property p_oe; data_oe |-> dir && $past(dir); endproperty
	property p_ta; $rose(dir) |-> !data_oe; endproperty
	property p_one; data_oe |=> !data_oe && !dir; endproperty
	property p_nxt; nxt |-> !dir; endproperty
	property p_rd; $rose(dir) && $past(nxt) |-> !nxt ##1 data_oe; endproperty
	property p_cmd; $rose(nxt) |-> $past(data_in, 2) != 8'h00; endproperty
	property p_sts; $rose(dir) && !$past(nxt) |-> $past(sync_mode); endproperty
	property p_nlen; $rose(nxt) |-> ##[1:4] !nxt; endproperty
	a_oe: assert property (p_oe) else $error("bus driven without dir");
	a_ta: assert property (p_ta) else $error("no turnaround on dir rise");
	a_one: assert property (p_one) else $error("read byte not one cycle");
	a_nxt: assert property (p_nxt) else $error("nxt with dir high");
	a_rd: assert property (p_rd) else $error("read handover wrong");
	a_cmd: assert property (p_cmd) else $error("nxt without command");
	a_sts: assert property (p_sts) else $error("status outside sync mode");
	a_nlen: assert property (p_nlen) else $error("nxt held too long");
	c_rd: cover property ($rose(dir) && $past(nxt));
	c_sts: cover property ($rose(dir) && !$past(nxt));
	c_ext: cover property (nxt [*3]);
endmodule // urp_props
bind urp_protocol urp_props u_props (.clk_sys(clk_sys), .rst_n(rst_n), .data_in(data_in),
	.data_oe(data_oe), .dir(dir), .nxt(nxt), .sync_mode(sync_mode));
`default_nettype wire

/* dv/urp_link.sv */
// link-side partner model driving the ulpi bus
`timescale 1ns/10ps
`default_nettype none
module urp_link (
	input  wire logic       clk_sys,
	input  wire logic [7:0] data_out,
	input  wire logic       data_oe,
	input  wire logic       dir,
	input  wire logic       nxt,
	output wire logic [7:0] data_in,
	output var  logic       stp
);
	logic [7:0] ld_ff = 8'h00;
	int         n;
	int         n_to = 0;
	// a released bus shows the inverse of the last byte
	assign data_in = data_oe ? data_out : (dir ? ~ld_ff : ld_ff);
	initial stp = 1'b0;
	// wait for nxt (0), data_oe (1) or dir low (2)
	task ww(input int k);
		n = 0;
		do begin
			@(negedge clk_sys);
			n++;
		end while (n < 20 && !(k == 0 ? nxt : k == 1 ? data_oe : !dir));
		if (n == 20)
			n_to++;
	endtask
	task xfer(input logic [7:0] cmd, input logic [7:0] a, input logic [7:0] wd, output logic [7:0] q);
		ww(2);
		ld_ff = cmd;
		ww(0);
		@(negedge clk_sys);
		if (cmd[7] && cmd[5:0] == 6'h2f) begin
			ld_ff = a;
			@(negedge clk_sys);
		end
		if (cmd[7:6] == 2'b11) begin
			ld_ff = 8'h00;
			ww(1);
			q = data_in;
			ww(2);
			// idle stands one cycle after the turnaround before any new command
			@(negedge clk_sys);
		end else begin
			if (cmd[7]) begin
				ld_ff = wd;
				@(negedge clk_sys);
			end
			ld_ff = 8'h00;
			stp = 1'b1;
			@(negedge clk_sys);
			stp = 1'b0;
		end
	endtask
endmodule // urp_link
`default_nettype wire

/* dv/tb.sv */
// self-checking bench for the ulpi protocol block
`timescale 1ns/10ps
`default_nettype none
module tb;
	logic       clk_sys = 1'b0;
	logic       rst_n = 1'b0;
	logic       sync_mode = 1'b1;
	logic       status_req = 1'b0;
	logic       id_state = 1'b0;
	logic [1:0] line_state = 2'b00;
	logic [1:0] vbus_state = 2'b00;
	logic [1:0] rx_event = 2'b00;
	logic [7:0] data_in, data_out, q, a;
	logic       data_oe, dir, nxt, stp, tx_start;
	logic [3:0] tx_pid;
	int         fail_count = 0;
	int         num_checks = 0;
	int         tx_seen = 0;
	always #10 clk_sys = ~clk_sys;
	// count transmit start pulses on the settled half of the cycle
	always @(negedge clk_sys) begin
		if (tx_start)
			tx_seen++;
	end
	urp_protocol dut (.clk_sys(clk_sys), .rst_n(rst_n), .data_in(data_in), .data_out(data_out),
		.data_oe(data_oe), .dir(dir), .nxt(nxt), .stp(stp), .sync_mode(sync_mode),
		.line_state(line_state), .vbus_state(vbus_state), .rx_event(rx_event), .id_state(id_state),
		.status_req(status_req), .tx_start(tx_start), .tx_pid(tx_pid));
	urp_link link (.clk_sys(clk_sys), .data_out(data_out), .data_oe(data_oe), .dir(dir), .nxt(nxt),
		.data_in(data_in), .stp(stp));
	task chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task test_done;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task t_imm;
		for (int i = 0; i < 3; i++) begin
			a = 8'(i * 19 + 1);
			link.xfer({2'b10, a[5:0]}, 8'h00, ~a, q);
		end
		for (int i = 0; i < 3; i++) begin
			a = 8'(i * 19 + 1);
			link.xfer({2'b11, a[5:0]}, 8'h00, 8'h00, q);
			chk(q, ~a);
		end
		link.xfer(8'hfe, 8'h00, 8'h00, q);
		chk(q, 8'h00);
		$display("imm done");
	endtask
	task t_ext;
		link.xfer(8'haf, 8'hb5, 8'h3c, q);
		link.xfer(8'hef, 8'hb5, 8'h00, q);
		chk(q, 8'h3c);
		$display("ext done");
	endtask
	task t_tx;
		link.xfer(8'h45, 8'h00, 8'h00, q);
		chk({4'h0, tx_pid}, 8'h05);
		link.xfer(8'h40, 8'h00, 8'h00, q);
		chk({4'h0, tx_pid}, 8'h00);
		chk(8'(tx_seen), 8'h02);
		$display("tx done");
	endtask
	task t_sts;
		{id_state, rx_event, vbus_state, line_state} = 7'h5e;
		sync_mode = 1'b0;
		status_req = 1'b1;
		@(negedge clk_sys);
		status_req = 1'b0;
		repeat (6) begin
			@(negedge clk_sys);
			chk({7'h00, dir}, 8'h00);
		end
		sync_mode = 1'b1;
		// a request raised outside synchronous mode is dropped, so raise it again
		status_req = 1'b1;
		@(negedge clk_sys);
		status_req = 1'b0;
		link.ww(1);
		chk(data_in, 8'h5e);
		link.ww(2);
		$display("sts done");
	endtask
	initial begin
		repeat (3) @(negedge clk_sys);
		rst_n = 1'b1;
		t_imm();
		t_ext();
		t_tx();
		t_sts();
		chk(8'(link.n_to), 8'h00);
		test_done();
	end
	initial begin
		#100000;
		fail_count++;
		test_done();
	end
endmodule // tb
`default_nettype wire
